// [rtl/osc_switch_ctrl.sv]
// Purpose: Oscillator control registers and hardware clock-switch sequencer
// Assumes: APB slave on pclk; source ready and new-clock ticks come from pins
// Notes:   Byte-wise unlock through pstrb lanes of the control word
`timescale 1ns/1ps
`include "osc_switch_defs.svh"

// Behaviour
// - current_source_sel reports the active clock using the eight-code source encoding
// - selection_lock is set-only and, with the monitor on, blocks switch starts
// - pin_map_lock changes only after unlock; one_way_pin_lock forbids clearing it
// - multiplier_settled shows multiplier lock; cleared on switch or non-multiplier source
// - clock_fail_flag set by monitor failure; software may only clear it
// - primary_osc_sleep_keep keeps the primary oscillator running through Sleep
// - secondary_osc_enable powers the secondary oscillator; selected source stays on
// - Writing switch_request starts a switch; hardware clears it when done
// - recover_on_irq lets any interrupt clear ratio_apply, restoring 1:1
// - cpu_periph_ratio selects a CPU slowdown of 2 to the code power
// - ratio_apply clear forces the ratio to 1:1
// - frc_postscale_sel divides the fast RC by 2 to the code power
// - frc_trim is a six-bit signed offset of the fast RC frequency
// - Switching disabled: initial_source_cfg shown, switch_request held at zero
// - Equal current and new selection aborts the switch and clears the request
// - A valid switch start clears multiplier_settled and clock_fail_flag
// - Power target, wait start-up timer for crystals and multiplier lock
// - After ready, count 10 new clocks, copy selection to change over, then clear request
// - Turn off the old source except guarded low-power RC or enabled secondary
// - Upper byte written only right after the 78h, 9Ah unlock pair
// - Lower byte written only right after the 46h, 57h unlock pair
// - Switching needs monitor cfg upper bit 0; monitor runs only at 00
module osc_switch_ctrl
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  switch_monitor_cfg,
	input  wire logic        one_way_pin_lock,
	input  osc_switch_pkg::src_t initial_source_cfg,
	input  wire logic        watchdog_enabled,
	input  wire logic        monitor_fail,
	input  wire logic        multiplier_locked,
	input  wire logic        crystal_ready,
	input  wire logic        new_clock_tick,
	input  wire logic        irq_event,
	input  wire logic        sleep_active,
	output logic [4:0]       osc_power,
	output logic             primary_osc_sleep_keep,
	output osc_switch_pkg::src_t active_source,
	output logic [7:0]       cpu_divide,
	output logic [8:0]       frc_divide,
	output logic [5:0]       frc_trim,
	output logic             pin_map_lock
);
	import osc_switch_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Source uses the multiplier
	function automatic logic uses_mult(input src_t s);
		uses_mult = (s == SRC_FRC_MULT) || (s == SRC_PRI_MULT);
	endfunction : uses_mult

	// Power bit index: 0 fast RC, 1 primary, 2 secondary, 3 low-power RC, 4 multiplier
	function automatic logic [4:0] power_of(input src_t s);
		unique case (s)
			SRC_FRC, SRC_FRC_DIV, SRC_RSVD: power_of = 5'h01;
			SRC_FRC_MULT:                   power_of = 5'h11;
			SRC_PRI:                        power_of = 5'h02;
			SRC_PRI_MULT:                   power_of = 5'h12;
			SRC_SEC:                        power_of = 5'h04;
			SRC_LOW_POWER_RC_OSC:                       power_of = 5'h08;
		endcase
	endfunction : power_of

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	src_t      current_source_sel;
	src_t      new_source_sel;
	logic      selection_lock;
	logic      multiplier_settled;
	logic      clock_fail_flag;
	logic      secondary_osc_enable;
	logic      switch_request;
	logic      recover_on_irq;
	logic [2:0] cpu_periph_ratio;
	logic      ratio_apply;
	logic [2:0] frc_postscale_sel;
	sw_state_t sw_state;
	unlock_t   hi_unlock;
	unlock_t   lo_unlock;
	logic [3:0] tick_count;
	logic [2:0] ready_sync;
	logic [2:0] tick_sync;
	logic      tick_seen;
	logic      cfg_loaded;
	logic [4:0] keep_power;

	logic      wr_en;
	logic      rd_en;
	logic      ctl_wr;
	logic      hi_wr;
	logic      lo_wr;
	logic      hi_ok;
	logic      lo_ok;
	logic      switch_enabled;
	logic      monitor_on;
	logic      target_ready;
	logic      new_tick;
	logic [31:0] next_prdata;

	// ----------------------------------------------------------------
	// Bus decode and configuration
	// ----------------------------------------------------------------
	assign wr_en          = psel && penable && pwrite;
	assign rd_en          = psel && !penable && !pwrite;
	assign ctl_wr         = wr_en && (paddr == `OFS_OSC_CONTROL);
	assign hi_wr          = ctl_wr && pstrb[1];
	assign lo_wr          = ctl_wr && pstrb[0];
	assign hi_ok          = hi_wr && (hi_unlock == UL_OPEN);
	assign lo_ok          = lo_wr && (lo_unlock == UL_OPEN);
	assign switch_enabled = !switch_monitor_cfg[1];
	assign monitor_on     = (switch_monitor_cfg == 2'b00);

	// Ready when crystal started (if primary) and multiplier locked (if used)
	assign target_ready = ((new_source_sel != SRC_PRI && new_source_sel != SRC_PRI_MULT)
		|| (ready_sync[2] && ready_sync[1]))
		&& (!uses_mult(new_source_sel) || multiplier_settled);
	assign new_tick = (tick_sync[2] && tick_sync[1]) && !tick_seen;

	// APB answers in the access cycle; no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && (paddr > `OFS_SOURCE_STATUS || paddr[1:0] != 2'b00);
		end
	end

	// Read mux
	always_comb
	begin
		next_prdata = 32'h0;
		unique case (paddr)
			`OFS_OSC_CONTROL:
			begin
				next_prdata[`CUR_SEL_LSB +: 3] = current_source_sel;
				next_prdata[`NEW_SEL_LSB +: 3] = new_source_sel;
				next_prdata[`SEL_LOCK_BIT]     = selection_lock;
				next_prdata[`PIN_LOCK_BIT]     = pin_map_lock;
				next_prdata[`MULT_OK_BIT]      = multiplier_settled;
				next_prdata[`FAIL_BIT]         = clock_fail_flag;
				next_prdata[`PRI_KEEP_BIT]     = primary_osc_sleep_keep;
				next_prdata[`SEC_EN_BIT]       = secondary_osc_enable;
				next_prdata[`SW_REQ_BIT]       = switch_request;
			end
			`OFS_CLOCK_DIVIDER:
			begin
				next_prdata[`RECOVER_BIT]     = recover_on_irq;
				next_prdata[`RATIO_LSB +: 3]  = cpu_periph_ratio;
				next_prdata[`APPLY_BIT]       = ratio_apply;
				next_prdata[`POST_LSB +: 3]   = frc_postscale_sel;
			end
			`OFS_FAST_RC_TRIM:  next_prdata[5:0] = frc_trim;
			`OFS_SOURCE_STATUS: next_prdata[4:0] = osc_power;
			default:            next_prdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (rd_en)
			prdata <= next_prdata;
	end

	// ----------------------------------------------------------------
	// Unlock detectors: key pair opens one write, any other write re-arms
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hi_unlock <= UL_NONE;
		else if (hi_wr)
		begin
			if (hi_unlock == UL_OPEN)
				hi_unlock <= UL_NONE;
			else if (hi_unlock == UL_NONE && pwdata[15:8] == `KEY_HI_1)
				hi_unlock <= UL_FIRST;
			else if (hi_unlock == UL_FIRST && pwdata[15:8] == `KEY_HI_2)
				hi_unlock <= UL_OPEN;
			else if (pwdata[15:8] == `KEY_HI_1)
				hi_unlock <= UL_FIRST;
			else
				hi_unlock <= UL_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lo_unlock <= UL_NONE;
		else if (lo_wr)
		begin
			if (lo_unlock == UL_OPEN)
				lo_unlock <= UL_NONE;
			else if (lo_unlock == UL_NONE && pwdata[7:0] == `KEY_LO_1)
				lo_unlock <= UL_FIRST;
			else if (lo_unlock == UL_FIRST && pwdata[7:0] == `KEY_LO_2)
				lo_unlock <= UL_OPEN;
			else if (pwdata[7:0] == `KEY_LO_1)
				lo_unlock <= UL_FIRST;
			else
				lo_unlock <= UL_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Upper byte: new selection, loaded from configuration after reset
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_loaded <= 1'b0;
		else
			cfg_loaded <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			new_source_sel <= SRC_FRC_DIV;
		else if (!cfg_loaded)
			new_source_sel <= initial_source_cfg;
		else if (hi_ok && !(selection_lock && monitor_on))
			new_source_sel <= src_t'(pwdata[`NEW_SEL_LSB +: 3]);
	end

	// ----------------------------------------------------------------
	// Lower byte control bits
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			selection_lock         <= 1'b0;
			pin_map_lock           <= 1'b0;
			primary_osc_sleep_keep <= 1'b0;
			secondary_osc_enable   <= 1'b0;
		end
		else if (lo_ok)
		begin
			if (pwdata[`SEL_LOCK_BIT])
				selection_lock <= 1'b1;
			if (!(one_way_pin_lock && pin_map_lock))
				pin_map_lock <= pwdata[`PIN_LOCK_BIT];
			primary_osc_sleep_keep <= pwdata[`PRI_KEEP_BIT];
			secondary_osc_enable   <= pwdata[`SEC_EN_BIT];
		end
	end

	// Fail flag: monitor set wins over software clear and switch start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clock_fail_flag <= 1'b0;
		else if (monitor_fail && monitor_on)
			clock_fail_flag <= 1'b1;
		else if (sw_state == SW_START)
			clock_fail_flag <= 1'b0;
		else if (lo_ok && !pwdata[`FAIL_BIT])
			clock_fail_flag <= 1'b0;
	end

	// Multiplier lock status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			multiplier_settled <= 1'b0;
		else if (sw_state == SW_START || !uses_mult(current_source_sel)
			&& !uses_mult(new_source_sel))
			multiplier_settled <= 1'b0;
		else
			multiplier_settled <= multiplier_locked;
	end

	// ----------------------------------------------------------------
	// Pin synchronisers: a rise counts once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_sync <= 3'h0;
			tick_sync  <= 3'h0;
			tick_seen  <= 1'b0;
		end
		else
		begin
			ready_sync <= {ready_sync[1:0], crystal_ready};
			tick_sync  <= {tick_sync[1:0], new_clock_tick};
			if (tick_sync[2] == tick_sync[1])
				tick_seen <= tick_sync[2];
		end
	end

	// ----------------------------------------------------------------
	// Switch sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_state           <= SW_IDLE;
			switch_request     <= 1'b0;
			current_source_sel <= SRC_FRC_DIV;
			tick_count         <= 4'h0;
		end
		else if (!cfg_loaded || !switch_enabled)
		begin
			sw_state           <= SW_IDLE;
			switch_request     <= 1'b0;
			current_source_sel <= initial_source_cfg;
		end
		else
		begin
			unique case (sw_state)
				SW_IDLE:
					if (lo_ok && pwdata[`SW_REQ_BIT] && !(selection_lock && monitor_on))
					begin
						switch_request <= 1'b1;
						if (new_source_sel == current_source_sel)
							sw_state <= SW_DONE;
						else
							sw_state <= SW_START;
					end
				SW_START:
				begin
					tick_count <= 4'h0;
					sw_state   <= SW_WAIT_READY;
				end
				SW_WAIT_READY:
					if (target_ready)
						sw_state <= SW_COUNT;
				SW_COUNT:
					if (new_tick)
					begin
						if (tick_count == `NEW_CLK_CYCLES - 4'h1)
						begin
							current_source_sel <= new_source_sel;
							sw_state           <= SW_DONE;
						end
						tick_count <= tick_count + 4'h1;
					end
				SW_DONE:
				begin
					switch_request <= 1'b0;
					sw_state       <= SW_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Oscillator power: old source off after switch, with exceptions
	// ----------------------------------------------------------------
	always_comb
	begin
		keep_power = power_of(current_source_sel);
		if (sw_state != SW_IDLE && sw_state != SW_DONE)
			keep_power = keep_power | power_of(new_source_sel);
		if (secondary_osc_enable)
			keep_power[2] = 1'b1;
		if (watchdog_enabled || monitor_on)
			keep_power[3] = 1'b1;
		if (sleep_active)
			keep_power[1] = keep_power[1] & primary_osc_sleep_keep;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_power     <= 5'h01;
			active_source <= SRC_FRC_DIV;
		end
		else
		begin
			osc_power     <= keep_power;
			active_source <= current_source_sel;
		end
	end

	// ----------------------------------------------------------------
	// Clock divider and trim registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			recover_on_irq    <= 1'b0;
			cpu_periph_ratio  <= 3'h0;
			frc_postscale_sel <= `RST_POST_SEL;
			frc_trim          <= 6'h00;
		end
		else if (wr_en && paddr == `OFS_CLOCK_DIVIDER && pstrb[1])
		begin
			recover_on_irq    <= pwdata[`RECOVER_BIT];
			cpu_periph_ratio  <= pwdata[`RATIO_LSB +: 3];
			frc_postscale_sel <= pwdata[`POST_LSB +: 3];
		end
		else if (wr_en && paddr == `OFS_FAST_RC_TRIM && pstrb[0])
			frc_trim <= pwdata[5:0];
	end

	// Interrupt recovery beats a software set of the apply bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ratio_apply <= 1'b0;
		else if (irq_event && recover_on_irq)
			ratio_apply <= 1'b0;
		else if (wr_en && paddr == `OFS_CLOCK_DIVIDER && pstrb[1])
			ratio_apply <= pwdata[`APPLY_BIT];
	end

	// Divide factors, powers of two
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cpu_divide <= 8'h01;
			frc_divide <= 9'h001;
		end
		else
		begin
			cpu_divide <= ratio_apply ? 8'(8'h01 << cpu_periph_ratio) : 8'h01;
			frc_divide <= 9'(9'h001 << frc_postscale_sel);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ratio_forced: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(ratio_apply) |-> cpu_divide == 8'h01)
		else $error("ratio not 1:1 while apply clear");
	a_irq_recover: assert property (@(posedge pclk) disable iff (!presetn)
		irq_event && recover_on_irq |=> !ratio_apply)
		else $error("interrupt did not clear apply");
	a_fail_set: assert property (@(posedge pclk) disable iff (!presetn)
		monitor_fail && monitor_on |=> clock_fail_flag)
		else $error("fail flag not set");
	a_start_clears: assert property (@(posedge pclk) disable iff (!presetn)
		sw_state == SW_START && !monitor_fail |=> !clock_fail_flag && !multiplier_settled)
		else $error("switch start did not clear flags");
	a_redundant_abort: assert property (@(posedge pclk) disable iff (!presetn)
		sw_state == SW_IDLE && lo_ok && pwdata[0] && switch_enabled && cfg_loaded
		&& !(selection_lock && monitor_on) && new_source_sel == current_source_sel
		|=> ##1 !switch_request && $stable(current_source_sel))
		else $error("redundant switch not aborted");
	a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!switch_enabled && cfg_loaded |=> !switch_request)
		else $error("request set while switching disabled");
	a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		selection_lock |=> selection_lock)
		else $error("selection lock cleared");
	a_pin_one_way: assert property (@(posedge pclk) disable iff (!presetn)
		pin_map_lock && one_way_pin_lock |=> pin_map_lock)
		else $error("one-way pin lock cleared");
	a_pin_unlock: assert property (@(posedge pclk) disable iff (!presetn)
		!lo_ok |=> $stable(pin_map_lock))
		else $error("pin lock changed without unlock");
	a_sel_unlock: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_loaded && !hi_ok |=> $stable(new_source_sel))
		else $error("selection changed without unlock");
	a_change_over: assert property (@(posedge pclk) disable iff (!presetn)
		sw_state == SW_COUNT && new_tick && tick_count == 4'h9 && switch_enabled
		|=> current_source_sel == $past(new_source_sel) ##1 !switch_request)
		else $error("change-over wrong");

endmodule : osc_switch_ctrl

// [rtl/osc_switch_defs.svh]
// Purpose: Offsets, field positions, reset values and timing counts for the oscillator control block
// Assumes: APB byte addresses, one register to a 32-bit word
// Notes:   Definitions only
`ifndef OSC_SWITCH_DEFS_SVH
`define OSC_SWITCH_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_OSC_CONTROL   12'h000
`define OFS_CLOCK_DIVIDER 12'h004
`define OFS_FAST_RC_TRIM  12'h008
`define OFS_SOURCE_STATUS 12'h00c

// ----------------------------------------------------------------
// Field positions in oscillator_control
// ----------------------------------------------------------------
`define CUR_SEL_LSB   12
`define NEW_SEL_LSB   8
`define SEL_LOCK_BIT  7
`define PIN_LOCK_BIT  6
`define MULT_OK_BIT   5
`define FAIL_BIT      3
`define PRI_KEEP_BIT  2
`define SEC_EN_BIT    1
`define SW_REQ_BIT    0

// ----------------------------------------------------------------
// Field positions in clock_divider
// ----------------------------------------------------------------
`define RECOVER_BIT   15
`define RATIO_LSB     12
`define APPLY_BIT     11
`define POST_LSB      8

// ----------------------------------------------------------------
// Unlock keys and reset values
// ----------------------------------------------------------------
`define KEY_HI_1      8'h78
`define KEY_HI_2      8'h9a
`define KEY_LO_1      8'h46
`define KEY_LO_2      8'h57
`define RST_POST_SEL  3'h1

// ----------------------------------------------------------------
// Timing: cycles of the new clock before the change-over
// ----------------------------------------------------------------
`define NEW_CLK_CYCLES 4'ha

`endif

// [rtl/osc_switch_pkg.sv]
// Purpose: Types shared by the oscillator control block
// Assumes: osc_switch_defs.svh carries all numbers except the source and state codes defined here
// Notes:   Source codes follow the selection field encoding
package osc_switch_pkg;

	// Clock source codes
	typedef enum logic [2:0]
	{
		SRC_FRC      = 3'h0,
		SRC_FRC_MULT = 3'h1,
		SRC_PRI      = 3'h2,
		SRC_PRI_MULT = 3'h3,
		SRC_SEC      = 3'h4,
		SRC_LOW_POWER_RC_OSC     = 3'h5,
		SRC_RSVD     = 3'h6,
		SRC_FRC_DIV  = 3'h7
	} src_t;

	// Switch sequencer states
	typedef enum logic [2:0]
	{
		SW_IDLE,
		SW_START,
		SW_WAIT_READY,
		SW_COUNT,
		SW_DONE
	} sw_state_t;

	// Unlock detector states
	typedef enum logic [1:0]
	{
		UL_NONE,
		UL_FIRST,
		UL_OPEN
	} unlock_t;

endpackage : osc_switch_pkg

// [test/tb.sv]
// Purpose: Self-checking bench for the oscillator control block over APB
// Assumes: Zero-wait APB slave, control at offset 0, unlock pairs per byte lane
// Notes:   Reads queue their expectations; a monitor compares on each read
`timescale 1ns/1ps
`include "osc_switch_defs.svh"
module tb;
	import osc_switch_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  cfg = 2'b00;
	src_t        init_src = SRC_FRC;
	logic        mon_fail = 1'b0;
	logic        irq = 1'b0;
	logic        sleep = 1'b0;
	logic        tick = 1'b0;
	logic        owl = 1'b1;
	logic [1:0]  tdiv = 2'h0;
	logic [4:0]  osc_power;
	logic        keep;
	src_t        active_source;
	logic [7:0]  cpu_divide;
	logic [8:0]  frc_divide;
	logic [5:0]  frc_trim;
	logic        pin_map_lock;
	logic [31:0] q;
	logic [31:0] rnd = 32'd85;
	exp_t        expq[$];
	exp_t        e;
	int          err_count = 0;
	int          total_checks = 0;

	// Clock and a slow free-running new-clock pin
	always #2.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		tdiv <= tdiv + 2'h1;
		if (tdiv == 2'h3)
			tick <= ~tick;
	end

	osc_switch_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .switch_monitor_cfg(cfg), .one_way_pin_lock(owl),
		.initial_source_cfg(init_src), .watchdog_enabled(1'b0), .monitor_fail(mon_fail),
		.multiplier_locked(1'b1), .crystal_ready(1'b1), .new_clock_tick(tick),
		.irq_event(irq), .sleep_active(sleep), .osc_power(osc_power),
		.primary_osc_sleep_keep(keep), .active_source(active_source), .cpu_divide(cpu_divide),
		.frc_divide(frc_divide), .frc_trim(frc_trim), .pin_map_lock(pin_map_lock));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	// Monitor: compare each completed read with the oldest note
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
		begin
			e = expq.pop_front();
			chk("prdata", e.d & e.m, prdata & e.m);
			chk("pslverr", 32'(e.e), 32'(pslverr));
		end

	// One APB transfer, released with one idle cycle after it
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
		begin
			err_count++;
			$display("[FAIL] pready expected 1 seen 0");
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic er);
		expq.push_back('{d, m, er});
		xfer(1'b0, a, d, 4'h0);
	endtask : rd

	// Unlocked byte writes: upper lane then lower lane
	task automatic hi(input logic [7:0] v);
		xfer(1'b1, `OFS_OSC_CONTROL, {16'h0, `KEY_HI_1, 8'h00}, 4'h2);
		xfer(1'b1, `OFS_OSC_CONTROL, {16'h0, `KEY_HI_2, 8'h00}, 4'h2);
		xfer(1'b1, `OFS_OSC_CONTROL, {16'h0, v, 8'h00}, 4'h2);
	endtask : hi

	task automatic lo(input logic [7:0] v);
		xfer(1'b1, `OFS_OSC_CONTROL, {24'h0, `KEY_LO_1}, 4'h1);
		xfer(1'b1, `OFS_OSC_CONTROL, {24'h0, `KEY_LO_2}, 4'h1);
		xfer(1'b1, `OFS_OSC_CONTROL, {24'h0, v}, 4'h1);
	endtask : lo

	// Poll until the switch request bit drops
	task automatic sw_wait();
		for (int k = 0; k < 80; k++)
		begin
			rd(`OFS_OSC_CONTROL, 32'h0, 32'h0, 1'b0);
			if (q[0] === 1'b0)
				break;
		end
	endtask : sw_wait

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask : do_reset

	task automatic print_verdict();
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// Watchdog against a hung run
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_count++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		do_reset();
		rd(`OFS_OSC_CONTROL, 32'h0000, 32'hffff_ffff, 1'b0);
		rd(`OFS_CLOCK_DIVIDER, 32'h0100, 32'hffff_ffff, 1'b0);
		xfer(1'b1, `OFS_OSC_CONTROL, 32'h0000_0200, 4'h2);
		rd(`OFS_OSC_CONTROL, 32'h0000, 32'h0700, 1'b0);
		hi({5'h0, SRC_PRI});
		lo(8'h03);
		rd(`OFS_OSC_CONTROL, 32'h0201, 32'h0701, 1'b0);
		sw_wait();
		rd(`OFS_OSC_CONTROL, 32'h2202, 32'hffff, 1'b0);
		rd(`OFS_SOURCE_STATUS, 32'h0e, 32'h1f, 1'b0);
		chk("active_source", 32'(SRC_PRI), 32'(active_source));
		hi({5'h0, SRC_PRI});
		lo(8'h03);
		repeat (4) @(posedge pclk);
		rd(`OFS_OSC_CONTROL, 32'h2202, 32'hffff, 1'b0);
		mon_fail <= 1'b1;
		@(posedge pclk);
		mon_fail <= 1'b0;
		rd(`OFS_OSC_CONTROL, 32'h220a, 32'hffff, 1'b0);
		hi({5'h0, SRC_PRI_MULT});
		lo(8'h0b);
		sw_wait();
		rd(`OFS_OSC_CONTROL, 32'h3322, 32'hffff, 1'b0);
		rd(`OFS_SOURCE_STATUS, 32'h1e, 32'h1f, 1'b0);
		lo(8'h46);
		chk("pin_map_lock", 32'h1, 32'(pin_map_lock));
		chk("sleep_keep", 32'h1, 32'(keep));
		lo(8'h02);
		rd(`OFS_OSC_CONTROL, 32'h3362, 32'hffff, 1'b0);
		lo(8'hc2);
		hi({5'h0, SRC_FRC});
		lo(8'hc3);
		repeat (60) @(posedge pclk);
		rd(`OFS_OSC_CONTROL, 32'h33e2, 32'hfffe, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			xfer(1'b1, `OFS_CLOCK_DIVIDER, {16'h0, 1'b0, 3'(i), 1'b1, 3'(i), 8'h0}, 4'h2);
			repeat (2) @(posedge pclk);
			chk("cpu_divide", 32'h1 << i, 32'(cpu_divide));
			chk("frc_divide", 32'h1 << i, 32'(frc_divide));
		end
		xfer(1'b1, `OFS_CLOCK_DIVIDER, 32'h0000_5700, 4'h2);
		repeat (2) @(posedge pclk);
		chk("cpu_divide", 32'h1, 32'(cpu_divide));
		xfer(1'b1, `OFS_CLOCK_DIVIDER, 32'h0000_cf00, 4'h2);
		irq <= 1'b1;
		@(posedge pclk);
		irq <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("cpu_divide", 32'h1, 32'(cpu_divide));
		rd(`OFS_CLOCK_DIVIDER, 32'hc700, 32'hffff, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			rnd = xs(rnd);
			sleep <= rnd[8];
			xfer(1'b1, `OFS_FAST_RC_TRIM, rnd, 4'h1);
			rd(`OFS_FAST_RC_TRIM, {26'h0, rnd[5:0]}, 32'hffff_ffff, 1'b0);
			chk("frc_trim", {26'h0, rnd[5:0]}, 32'(frc_trim));
		end
		rd(12'h010, 32'h0, 32'hffff_ffff, 1'b1);
		cfg <= 2'b10;
		init_src <= SRC_LOW_POWER_RC_OSC;
		owl <= 1'b0;
		do_reset();
		rd(`OFS_OSC_CONTROL, 32'h5000, 32'h7001, 1'b0);
		lo(8'h40);
		chk("pin_map_lock", 32'h1, 32'(pin_map_lock));
		hi({5'h0, SRC_FRC});
		lo(8'h01);
		chk("pin_map_lock", 32'h0, 32'(pin_map_lock));
		rd(`OFS_OSC_CONTROL, 32'h5000, 32'h7001, 1'b0);
		repeat (4) @(posedge pclk);
		chk("active_source", 32'(SRC_LOW_POWER_RC_OSC), 32'(active_source));
		print_verdict();
	end
endmodule : tb
